/* File: hw/gpio_port_pkg.sv */
// Shared constants and types for the eight-pin general-purpose port.
package gpio_port_pkg;

    // Number of pins served by one port.
    localparam int PIN_COUNT = 8;

    // Offsets in the full register map.
    localparam logic [4:0] OFS_DRIVE_ENABLE      = 5'h00;
    localparam logic [4:0] OFS_DRIVE_ENABLE_SET  = 5'h01;
    localparam logic [4:0] OFS_DRIVE_ENABLE_CLR  = 5'h02;
    localparam logic [4:0] OFS_DRIVE_ENABLE_TGL  = 5'h03;
    localparam logic [4:0] OFS_DRIVE_LEVEL       = 5'h04;
    localparam logic [4:0] OFS_DRIVE_LEVEL_SET   = 5'h05;
    localparam logic [4:0] OFS_OUTPUT_CLEAR      = 5'h06;
    localparam logic [4:0] OFS_OUTPUT_TOGGLE     = 5'h07;
    localparam logic [4:0] OFS_PIN_SAMPLE        = 5'h08;
    localparam logic [4:0] OFS_PIN_EVENT_FLAGS   = 5'h09;
    localparam logic [4:0] OFS_PAD_SETUP_BASE    = 5'h10;
    localparam logic [4:0] OFS_PAD_SETUP_LAST    = 5'h17;

    // Offsets in the short alias map.
    localparam logic [4:0] OFS_ALIAS_DRIVE_ENABLE = 5'h00;
    localparam logic [4:0] OFS_ALIAS_DRIVE_LEVEL  = 5'h01;
    localparam logic [4:0] OFS_ALIAS_PIN_SAMPLE   = 5'h02;
    localparam logic [4:0] OFS_ALIAS_EVENT_FLAGS  = 5'h03;

    // Field positions and writable bits of a pad setup register.
    localparam int         POLARITY_FLIP_BIT = 7;
    localparam int         WEAK_HIGH_BIT     = 3;
    localparam int         SENSE_LSB         = 0;
    localparam logic [7:0] PAD_SETUP_MASK    = 8'h8F;

    // Reset values.
    localparam logic [7:0] BYTE_RESET      = 8'h00;
    localparam logic [7:0] PAD_SETUP_RESET = 8'h00;

    // Input sense selections.
    typedef enum logic [2:0] {
        SENSE_OFF_BUFFER_ON = 3'h0,
        SENSE_ANY_EDGE      = 3'h1,
        SENSE_RISE_EDGE     = 3'h2,
        SENSE_FALL_EDGE     = 3'h3,
        SENSE_BUFFER_OFF    = 3'h4,
        SENSE_LOW_LEVEL     = 3'h5
    } sense_type;

    // Layout of one pad setup register.
    typedef struct packed {
        logic       polarity_flip;
        logic [2:0] unused_bits;
        logic       weak_high_bias_on;
        logic [2:0] sense_select;
    } pad_setup_type;

    // One register access as presented by the processor side.
    typedef struct packed {
        logic       alias_sel;
        logic [4:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_req_type;

endpackage

/* File: hw/gpio_port.sv */
// Eight-pin general-purpose port: registers, pin drive and pin-change sensing.
//
// How it works
// R1: one bits in clear strobe clear levels
// R2: both strobe registers read back drive level
// R3: toggle strobe at 0x07 inverts level bits
// R4: sample register at 0x08 shows pin levels
// R5: disabled input buffer hides pin, stops sensing
// R6: sample register write toggles drive level bits
// R7: flag at 0x09 sets on matching sense
// R8: writing one clears a flag bit
// R9: setup at 0x10+n, bit 7 inverts pin
// R10: setup bit 3 turns on weak pull-up
// R11: sense 1 any, 2 rising, 3 falling edge
// R12: sense 0 no events, 4 disables buffer
// R13: sense 5 flags low level, others reserved
// R14: alias map mirrors full registers, but alias flags are masked by irq_en
// R15: alias sample write toggles drive level
// R16: alias flags show only interrupt-enabled pins
// R17: drive enable one makes pin an output
// R18: drive level reaches pin only when driving
// R19: pin synchroniser runs on main clock
// R20: one request while enabled flag is set
// R21: flag set wins over same-cycle clear
`timescale 1ns/1ps

module gpio_port
    import gpio_port_pkg::*;
#(
    parameter int PINS = PIN_COUNT
)
(
    input  wire logic              clk,           // Main system clock.
    input  wire logic              nrst,          // Asynchronous reset, active low.
    input  wire reg_req_type       reg_req,       // Register access request.
    output logic [7:0]             reg_rdata,     // Read data, valid after a read.
    input  wire logic [PINS-1:0]   pin_in,        // Levels seen on the pins.
    output logic [PINS-1:0]        pin_out,       // Level driven onto each pin.
    output logic [PINS-1:0]        pin_oe,        // High while the pin is driven.
    output logic [PINS-1:0]        pin_pullup_en, // Weak pull-up enable per pin.
    output logic                   port_irq       // Port interrupt request.
);

    // True when the request writes the given offset in the given map.
    function automatic logic wr_hit(input reg_req_type r, input logic alias_map,
                                    input logic [4:0] ofs);
        wr_hit = r.wr && (r.alias_sel == alias_map) && (r.addr == ofs);
    endfunction

    // True when a pad setting lets the pin raise port interrupts.
    function automatic logic irq_source(input logic [2:0] s);
        irq_source = (s == SENSE_ANY_EDGE) || (s == SENSE_RISE_EDGE) ||
                     (s == SENSE_FALL_EDGE) || (s == SENSE_LOW_LEVEL);
    endfunction

    logic [PINS-1:0] drive_enable_ff;       // Per-pin direction state.
    logic [PINS-1:0] drive_level_ff;        // Per-pin output value state.
    logic [PINS-1:0] pin_event_flags_ff;    // Sticky pin-change flags.
    logic [PINS-1:0] pin_sample_value_ff;   // Sampled and polarity-corrected levels.
    logic [PINS-1:0] sync1_ff;              // Synchroniser first stage.
    logic [PINS-1:0] sync2_ff;              // Synchroniser second stage.
    logic [PINS-1:0] sync3_ff;              // Synchroniser third stage.
    logic [PINS-1:0] filt_ff;               // Level accepted once stages agree.
    logic [PINS-1:0] prev_ff;               // Corrected level one cycle ago.
    pad_setup_type   pad_setup_ff [PINS];   // Per-pin pad setup registers.
    logic [7:0]      reg_rdata_ff;          // Registered read data.
    logic [PINS-1:0] pin_out_ff;            // Registered pin drive level.
    logic [PINS-1:0] pin_oe_ff;             // Registered pin output enable.
    logic [PINS-1:0] pin_pullup_ff;         // Registered pull-up enable.
    logic            port_irq_ff;           // Registered interrupt request.

    logic [PINS-1:0] flip;                  // Polarity flip per pin.
    logic [PINS-1:0] buf_on;                // Input buffer enabled per pin.
    logic [PINS-1:0] irq_en;                // Pin is an interrupt source.
    logic [PINS-1:0] cur_lvl;               // Corrected level this cycle.
    logic [PINS-1:0] evt_set;               // Flag set events this cycle.
    logic [PINS-1:0] nxt_drive_enable;      // Next direction state.
    logic [PINS-1:0] nxt_drive_level;       // Next output value state.
    logic [PINS-1:0] nxt_flags;             // Next flag state.
    logic [7:0]      nxt_rdata;             // Read data for the addressed register.

    // Per-pin decode of the pad setup fields and sense matching.
    always_comb
    begin
        for (int n = 0; n < PINS; n++)
        begin
            flip[n]    = pad_setup_ff[n].polarity_flip;                      // [R9]
            buf_on[n]  = (pad_setup_ff[n].sense_select != SENSE_BUFFER_OFF); // [R12]
            irq_en[n]  = irq_source(pad_setup_ff[n].sense_select);
            cur_lvl[n] = filt_ff[n] ^ flip[n];                               // [R9]
            unique case (pad_setup_ff[n].sense_select)
                SENSE_ANY_EDGE:  evt_set[n] = cur_lvl[n] != prev_ff[n];      // [R11]
                SENSE_RISE_EDGE: evt_set[n] = cur_lvl[n] & ~prev_ff[n];     // [R11]
                SENSE_FALL_EDGE: evt_set[n] = ~cur_lvl[n] & prev_ff[n];     // [R11]
                SENSE_LOW_LEVEL: evt_set[n] = ~cur_lvl[n];                   // [R13]
                default:         evt_set[n] = 1'b0;                          // [R12] [R13]
            endcase
            evt_set[n] = evt_set[n] & buf_on[n];                             // [R5] [R7]
        end
    end

    // Next direction state from direct, set, clear and toggle writes.
    always_comb
    begin
        nxt_drive_enable = drive_enable_ff;
        if (wr_hit(reg_req, 1'b0, OFS_DRIVE_ENABLE) ||
            wr_hit(reg_req, 1'b1, OFS_ALIAS_DRIVE_ENABLE))                   // [R14]
        begin
            nxt_drive_enable = reg_req.wdata[PINS-1:0];
        end
        else if (wr_hit(reg_req, 1'b0, OFS_DRIVE_ENABLE_SET))
        begin
            nxt_drive_enable = drive_enable_ff | reg_req.wdata[PINS-1:0];
        end
        else if (wr_hit(reg_req, 1'b0, OFS_DRIVE_ENABLE_CLR))
        begin
            nxt_drive_enable = drive_enable_ff & ~reg_req.wdata[PINS-1:0];
        end
        else if (wr_hit(reg_req, 1'b0, OFS_DRIVE_ENABLE_TGL))
        begin
            nxt_drive_enable = drive_enable_ff ^ reg_req.wdata[PINS-1:0];
        end
    end

    // Next output value state from direct, set, clear and toggle writes.
    always_comb
    begin
        nxt_drive_level = drive_level_ff;
        if (wr_hit(reg_req, 1'b0, OFS_DRIVE_LEVEL) ||
            wr_hit(reg_req, 1'b1, OFS_ALIAS_DRIVE_LEVEL))                    // [R14]
        begin
            nxt_drive_level = reg_req.wdata[PINS-1:0];
        end
        else if (wr_hit(reg_req, 1'b0, OFS_DRIVE_LEVEL_SET))
        begin
            nxt_drive_level = drive_level_ff | reg_req.wdata[PINS-1:0];
        end
        else if (wr_hit(reg_req, 1'b0, OFS_OUTPUT_CLEAR))
        begin
            nxt_drive_level = drive_level_ff & ~reg_req.wdata[PINS-1:0];    // [R1]
        end
        else if (wr_hit(reg_req, 1'b0, OFS_OUTPUT_TOGGLE) ||                // [R3]
                 wr_hit(reg_req, 1'b0, OFS_PIN_SAMPLE) ||                   // [R6]
                 wr_hit(reg_req, 1'b1, OFS_ALIAS_PIN_SAMPLE))               // [R15]
        begin
            nxt_drive_level = drive_level_ff ^ reg_req.wdata[PINS-1:0];
        end
    end

    // Next flag state: a write of one clears, a new event sets and wins.
    always_comb
    begin
        nxt_flags = pin_event_flags_ff;
        if (wr_hit(reg_req, 1'b0, OFS_PIN_EVENT_FLAGS) ||
            wr_hit(reg_req, 1'b1, OFS_ALIAS_EVENT_FLAGS))                    // [R8] [R14]
        begin
            nxt_flags = pin_event_flags_ff & ~reg_req.wdata[PINS-1:0];
        end
        nxt_flags = nxt_flags | evt_set;                                     // [R7] [R21]
    end

    // Read data selection for both maps; unmapped offsets read zero.
    always_comb
    begin
        nxt_rdata = BYTE_RESET;
        if (reg_req.alias_sel)
        begin
            unique case (reg_req.addr)
                OFS_ALIAS_DRIVE_ENABLE: nxt_rdata[PINS-1:0] = drive_enable_ff;
                OFS_ALIAS_DRIVE_LEVEL:  nxt_rdata[PINS-1:0] = drive_level_ff;
                OFS_ALIAS_PIN_SAMPLE:   nxt_rdata[PINS-1:0] = pin_sample_value_ff;
                OFS_ALIAS_EVENT_FLAGS:  nxt_rdata[PINS-1:0] =
                                            pin_event_flags_ff & irq_en;     // [R16]
                default:                nxt_rdata = BYTE_RESET;
            endcase
        end
        else if (reg_req.addr >= OFS_PAD_SETUP_BASE && reg_req.addr <= OFS_PAD_SETUP_LAST)
        begin
            nxt_rdata = pad_setup_ff[reg_req.addr[2:0]];                     // [R9]
        end
        else
        begin
            unique case (reg_req.addr)
                OFS_DRIVE_ENABLE, OFS_DRIVE_ENABLE_SET,
                OFS_DRIVE_ENABLE_CLR, OFS_DRIVE_ENABLE_TGL:
                    nxt_rdata[PINS-1:0] = drive_enable_ff;
                OFS_DRIVE_LEVEL, OFS_DRIVE_LEVEL_SET,
                OFS_OUTPUT_CLEAR, OFS_OUTPUT_TOGGLE:
                    nxt_rdata[PINS-1:0] = drive_level_ff;                    // [R2]
                OFS_PIN_SAMPLE:      nxt_rdata[PINS-1:0] = pin_sample_value_ff; // [R4]
                OFS_PIN_EVENT_FLAGS: nxt_rdata[PINS-1:0] = pin_event_flags_ff;  // [R7]
                default:             nxt_rdata = BYTE_RESET;
            endcase
        end
    end

    // Direction and output value state.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            drive_enable_ff <= '0;
            drive_level_ff  <= '0;
        end
        else
        begin
            drive_enable_ff <= nxt_drive_enable;
            drive_level_ff  <= nxt_drive_level;
        end
    end

    // Pad setup registers; only the documented bits are kept.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int n = 0; n < PINS; n++)
            begin
                pad_setup_ff[n] <= pad_setup_type'(PAD_SETUP_RESET);
            end
        end
        else
        begin
            for (int n = 0; n < PINS; n++)
            begin
                if (wr_hit(reg_req, 1'b0, OFS_PAD_SETUP_BASE + 5'(n)))
                begin
                    pad_setup_ff[n] <= pad_setup_type'(reg_req.wdata & PAD_SETUP_MASK);
                end
            end
        end
    end

    // Three-stage pin synchroniser on the main clock; a new level is taken
    // only once the second and third stages agree.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
            filt_ff  <= '0;
        end
        else
        begin
            sync1_ff <= pin_in;                                              // [R19]
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            for (int n = 0; n < PINS; n++)
            begin
                if (sync2_ff[n] == sync3_ff[n])
                begin
                    filt_ff[n] <= sync3_ff[n];
                end
            end
        end
    end

    // Sampled value, previous level for edge sensing, and sticky flags.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_sample_value_ff <= '0;
            prev_ff             <= '0;
            pin_event_flags_ff  <= '0;
        end
        else
        begin
            pin_sample_value_ff <= cur_lvl & buf_on;                         // [R4] [R5]
            prev_ff             <= cur_lvl;
            pin_event_flags_ff  <= nxt_flags;
        end
    end

    // Registered pin drive and output enable; an input pin is never driven,
    // so its level bit is forced low to keep the pad quiet.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_out_ff <= '0;
            pin_oe_ff  <= '0;
        end
        else
        begin
            pin_oe_ff  <= drive_enable_ff;                                   // [R17]
            pin_out_ff <= (drive_level_ff ^ flip) & drive_enable_ff;        // [R9] [R18]
        end
    end

    // Registered weak pull-up enables, one per pin, taken from the pad setup.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_pullup_ff <= '0;
        end
        else
        begin
            for (int n = 0; n < PINS; n++)
            begin
                pin_pullup_ff[n] <= pad_setup_ff[n].weak_high_bias_on;       // [R10]
            end
        end
    end

    // One shared request, high while any interrupt-source pin holds a flag.
    // Flags on pins whose sense gives no interrupt never raise it.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            port_irq_ff <= 1'b0;
        end
        else
        begin
            port_irq_ff <= |(pin_event_flags_ff & irq_en);                   // [R20]
        end
    end

    // Read data is captured on a read strobe and then held until the next
    // read, so software may sample it late without losing it.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            reg_rdata_ff <= BYTE_RESET;
        end
        else if (reg_req.rd)
        begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

    assign pin_out       = pin_out_ff;
    assign pin_oe        = pin_oe_ff;
    assign pin_pullup_en = pin_pullup_ff;
    assign port_irq      = port_irq_ff;
    assign reg_rdata     = reg_rdata_ff;

endmodule // gpio_port

/* File: dv/gpio_port_pins.sv */
// Behavioural model of the pins and of the circuit wired to them.
`timescale 1ns/1ps
module gpio_port_pins
(
    input  wire logic       clk,     // Main clock.
    input  wire logic [7:0] pin_out, // Level the port drives.
    input  wire logic [7:0] pin_oe,  // Port drive enables.
    input  wire logic [7:0] pin_pu,  // Port pull-up enables.
    input  wire logic [7:0] ext_lvl, // Level the outside circuit drives.
    input  wire logic [7:0] ext_en,  // High where the outside circuit drives.
    output logic      [7:0] pin_in   // Resolved level on each pin.
);
    logic [7:0] last_ff = 8'h00; // Last level, so a floating pin can wander.

    // Keeps the previous level of every pin.
    always_ff @(posedge clk)
        last_ff <= pin_in;

    // The port drive wins, then the outside circuit, then the pull-up.
    // A pin nobody holds flips each cycle, so it never looks stable.
    always_comb
        for (int i = 0; i < 8; i++)
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_lvl[i] :
                        pin_pu[i] ? 1'b1 : ~last_ff[i];
endmodule // gpio_port_pins

/* File: dv/gpio_port_chk.sv */
// Timing checks on the port of the general-purpose pin block.
`timescale 1ns/1ps
module gpio_port_chk
    import gpio_port_pkg::*;
#(
    parameter int PINS = PIN_COUNT
)
(
    input wire logic            clk,           // Main clock.
    input wire logic            nrst,          // Reset, active low.
    input wire reg_req_type     reg_req,       // Register request.
    input wire logic [7:0]      reg_rdata,     // Read data.
    input wire logic [PINS-1:0] pin_in,        // Pin levels.
    input wire logic [PINS-1:0] pin_out,       // Driven levels.
    input wire logic [PINS-1:0] pin_oe,        // Drive enables.
    input wire logic [PINS-1:0] pin_pullup_en, // Pull-up enables.
    input wire logic            port_irq       // Interrupt request.
);
    // Writes of either map, split out to keep the properties short.
    wire fw = reg_req.wr && !reg_req.alias_sel;
    wire aw = reg_req.wr && reg_req.alias_sel;

    // All checks share one clock and its reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_oe_full;
        fw && reg_req.addr == OFS_DRIVE_ENABLE |-> ##2 pin_oe == $past(reg_req.wdata, 2);
    endproperty
    a_oe_full: assert property (p_oe_full)
        else $error("drive enable not taken from full map");
    property p_oe_alias;
        aw && reg_req.addr == OFS_ALIAS_DRIVE_ENABLE |-> ##2 pin_oe == $past(reg_req.wdata, 2);
    endproperty
    a_oe_alias: assert property (p_oe_alias)
        else $error("drive enable not taken from alias map");
    property p_out_gate;
        (pin_out & ~pin_oe) == '0;
    endproperty
    a_out_gate: assert property (p_out_gate)
        else $error("level driven on an undriven pin");
    property p_tgl;
        fw && reg_req.addr == OFS_OUTPUT_TOGGLE
            |-> ##2 pin_out == (($past(pin_out) ^ $past(reg_req.wdata, 2)) & pin_oe);
    endproperty
    a_tgl: assert property (p_tgl)
        else $error("toggle strobe did not invert levels");
    property p_tgl_in;
        fw && reg_req.addr == OFS_PIN_SAMPLE
            |-> ##2 pin_out == (($past(pin_out) ^ $past(reg_req.wdata, 2)) & pin_oe);
    endproperty
    a_tgl_in: assert property (p_tgl_in)
        else $error("sample write did not invert levels");
    property p_tgl_alias;
        aw && reg_req.addr == OFS_ALIAS_PIN_SAMPLE
            |-> ##2 pin_out == (($past(pin_out) ^ $past(reg_req.wdata, 2)) & pin_oe);
    endproperty
    a_tgl_alias: assert property (p_tgl_alias)
        else $error("alias sample write did not invert levels");
    property p_pull;
        fw && reg_req.addr == OFS_PAD_SETUP_BASE
            |-> ##2 pin_pullup_en[0] == $past(reg_req.wdata[WEAK_HIGH_BIT], 2);
    endproperty
    a_pull: assert property (p_pull)
        else $error("pull-up enable does not follow setup");
    property p_irq;
        reg_req.rd && reg_req.alias_sel && reg_req.addr == OFS_ALIAS_EVENT_FLAGS
            |=> port_irq == (reg_rdata != 8'h00);
    endproperty
    a_irq: assert property (p_irq)
        else $error("request disagrees with enabled flags");
endmodule // gpio_port_chk

bind gpio_port gpio_port_chk #(.PINS(PINS)) u_chk (.clk(clk), .nrst(nrst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en), .port_irq(port_irq));

/* File: dv/gpio_port_output_input_sense_bench.sv */
// Self-checking bench for the general-purpose pin block.
`timescale 1ns/1ps
module gpio_port_output_input_sense_bench;
    import gpio_port_pkg::*;

    logic        clk = 1'b0;     // Main clock.
    logic        nrst = 1'b0;    // Reset, active low.
    reg_req_type req = '0;       // Register request.
    logic [7:0]  rdata;          // Read data.
    logic [7:0]  pin_in;         // Resolved pin levels.
    logic [7:0]  pin_out;        // Driven levels.
    logic [7:0]  pin_oe;         // Drive enables.
    logic [7:0]  pin_pu;         // Pull-up enables.
    logic        irq;            // Interrupt request.
    logic [7:0]  ext_lvl = 8'h00; // Outside drive level.
    logic [7:0]  ext_en = 8'hFF;  // Outside drive enables.
    int          err_total = 0;  // Mismatches.
    int          checks = 0;     // Comparisons.

    // Clock of 8 ns period.
    always #4 clk = ~clk;

    gpio_port #(.PINS(8)) dut (.clk(clk), .nrst(nrst), .reg_req(req), .reg_rdata(rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pu),
        .port_irq(irq));
    gpio_port_pins u_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pu(pin_pu), .ext_lvl(ext_lvl), .ext_en(ext_en), .pin_in(pin_in));

    // Compares one byte and counts the outcome.
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // One write cycle.
    task automatic wr(input logic al, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= {al, a, 1'b1, 1'b0, d};
        @(posedge clk);
        req <= '0;
    endtask

    // One read cycle; data is judged once the answering edge has passed.
    task automatic rd_chk(input logic al, input logic [4:0] a, input logic [7:0] e);
        @(posedge clk);
        req <= {al, a, 1'b0, 1'b1, 8'h00};
        @(posedge clk);
        req <= '0;
        #1 chk(rdata, e);
    endtask

    // Waits n clock edges.
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Every offset of both maps reads zero after reset.
    task automatic t_reset();
        for (int i = 0; i < 24; i++)
            rd_chk(1'b0, 5'(i), 8'h00);
        for (int i = 0; i < 4; i++)
            rd_chk(1'b1, 5'(i), 8'h00);
    endtask

    // Clear, toggle and sample-write strobes on the drive level.
    task automatic t_drive();
        wr(1'b0, OFS_DRIVE_ENABLE, 8'hFF);
        wr(1'b0, OFS_DRIVE_LEVEL, 8'h5A);
        wr(1'b0, OFS_OUTPUT_CLEAR, 8'h0F);
        rd_chk(1'b0, OFS_OUTPUT_CLEAR, 8'h50);
        wr(1'b0, OFS_OUTPUT_TOGGLE, 8'h11);
        rd_chk(1'b0, OFS_OUTPUT_TOGGLE, 8'h41);
        wr(1'b0, OFS_PIN_SAMPLE, 8'h03);
        rd_chk(1'b0, OFS_DRIVE_LEVEL, 8'h42);
        wr(1'b1, OFS_ALIAS_PIN_SAMPLE, 8'h80);
        rd_chk(1'b1, OFS_ALIAS_DRIVE_LEVEL, 8'hC2);
        chk(pin_out, 8'hC2);
        wr(1'b1, OFS_ALIAS_DRIVE_ENABLE, 8'h0F);
        idle(2);
        #1 chk(pin_out, 8'h02);
        chk(pin_oe, 8'h0F);
        wr(1'b0, OFS_PAD_SETUP_BASE + 5'h01, 8'h80);
        idle(2);
        #1 chk(pin_out, 8'h00);
        wr(1'b0, OFS_PAD_SETUP_BASE + 5'h01, 8'h00);
        wr(1'b0, OFS_DRIVE_ENABLE, 8'h00);
    endtask

    // Sampling, disabled buffer, inversion and pull-up.
    task automatic t_input();
        @(posedge clk);
        ext_lvl <= 8'hA1;
        idle(8);
        rd_chk(1'b0, OFS_PIN_SAMPLE, 8'hA1);
        wr(1'b0, OFS_PAD_SETUP_BASE, 8'h0C);
        wr(1'b0, OFS_PAD_SETUP_BASE + 5'h01, 8'hF0);
        rd_chk(1'b0, OFS_PAD_SETUP_BASE + 5'h01, 8'h80);
        wr(1'b0, OFS_PAD_SETUP_BASE + 5'h02, 8'h08);
        ext_en <= 8'hFB;
        idle(8);
        rd_chk(1'b0, OFS_PIN_SAMPLE, 8'hA6);
        chk(pin_pu, 8'h05);
        @(posedge clk);
        ext_en <= 8'hFF;
        ext_lvl <= 8'h01;
        for (int i = 0; i < 3; i++)
            wr(1'b0, OFS_PAD_SETUP_BASE + 5'(i), 8'h00);
    endtask

    // Every sense code on pin 0, with a fall and then a rise.
    task automatic t_sense();
        logic [7:0] fe;
        logic [7:0] re;
        for (int c = 0; c < 8; c++)
        begin
            fe = (c == 1 || c == 3 || c == 5) ? 8'h01 : 8'h00;
            re = (c == 1 || c == 2 || c == 5) ? 8'h01 : 8'h00;
            wr(1'b0, OFS_PAD_SETUP_BASE, 8'(c));
            idle(8);
            wr(1'b0, OFS_PIN_EVENT_FLAGS, 8'hFF);
            ext_lvl <= 8'h00;
            idle(8);
            rd_chk(1'b0, OFS_PIN_EVENT_FLAGS, fe);
            chk({7'h00, irq}, fe);
            rd_chk(1'b1, OFS_ALIAS_EVENT_FLAGS, fe);
            wr(1'b1, OFS_ALIAS_EVENT_FLAGS, 8'hFF);
            rd_chk(1'b0, OFS_PIN_EVENT_FLAGS, (c == 5) ? 8'h01 : 8'h00);
            @(posedge clk);
            ext_lvl <= 8'h01;
            idle(8);
            rd_chk(1'b0, OFS_PIN_EVENT_FLAGS, re);
            wr(1'b0, OFS_PIN_EVENT_FLAGS, 8'hFF);
            idle(2);
            rd_chk(1'b0, OFS_PIN_EVENT_FLAGS, 8'h00);
            chk({7'h00, irq}, 8'h00);
        end
    endtask

    // A flag left on a pin that stopped being an interrupt source is hidden
    // from the alias map and no longer raises the request.
    task automatic t_mask();
        wr(1'b0, OFS_PAD_SETUP_BASE, 8'h01);
        idle(8);
        wr(1'b0, OFS_PIN_EVENT_FLAGS, 8'hFF);
        ext_lvl <= 8'h00;
        idle(8);
        wr(1'b0, OFS_PAD_SETUP_BASE, 8'h00);
        idle(2);
        rd_chk(1'b0, OFS_PIN_EVENT_FLAGS, 8'h01);
        rd_chk(1'b1, OFS_ALIAS_EVENT_FLAGS, 8'h00);
        chk({7'h00, irq}, 8'h00);
        wr(1'b0, OFS_PIN_EVENT_FLAGS, 8'hFF);
    endtask

    // Prints the verdict and ends the run.
    task automatic close_out();
        if (err_total == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Main sequence.
    initial
    begin
        idle(6);
        nrst <= 1'b1;
        t_reset();
        t_drive();
        t_input();
        t_sense();
        t_mask();
        close_out();
    end

    // Cuts a hang short well after the expected run of about 520 cycles.
    initial
    begin
        #100000;
        err_total++;
        close_out();
    end
endmodule // gpio_port_output_input_sense_bench
